// ===== common/bpc_pkg.sv
// Shared constants and carriers for the blit pattern and copy command block.
// Assumes a 32-bit command stream of dwords and byte addressed graphics memory.
package bpc_pkg;
	// Packet identification
	localparam logic [2:0] CLIENT_2D = 3'h2;
	localparam logic [6:0] OP_COPY = 7'h53;
	localparam logic [6:0] OP_KEYED = 7'h73;
	localparam logic [6:0] OP_FIXED = 7'h59;
	localparam logic [7:0] LEN_COPY = 8'h06;
	localparam logic [7:0] LEN_KEYED = 8'h08;
	localparam logic [7:0] LEN_FIXED = 8'h05;
	localparam int NDW = 9;
	// Colour depth codes
	localparam logic [1:0] DEPTH_8 = 2'h0;
	localparam logic [1:0] DEPTH_565 = 2'h1;
	localparam logic [1:0] DEPTH_1555 = 2'h2;
	localparam logic [1:0] DEPTH_32 = 2'h3;
	// Fixed pattern selector codes
	localparam logic [3:0] PAT_HORIZ = 4'h0;
	localparam logic [3:0] PAT_VERT = 4'h1;
	localparam logic [3:0] PAT_FDIAG = 4'h2;
	localparam logic [3:0] PAT_BDIAG = 4'h3;
	localparam logic [3:0] PAT_CROSS = 4'h4;
	localparam logic [3:0] PAT_DCROSS = 4'h5;
	localparam logic [3:0] PAT_CHECK = 4'h8;
	localparam logic [3:0] PAT_WIDE = 4'h9;
	localparam logic [3:0] PAT_WALK1 = 4'hA;
	localparam logic [3:0] PAT_WALK0 = 4'hB;
	// Pattern row bytes, bit 7 is pixel 0
	localparam logic [2:0] HORIZ_LINE = 3'h3;
	localparam logic [7:0] ROW_NONE = 8'h00;
	localparam logic [7:0] ROW_FULL = 8'hFF;
	localparam logic [7:0] ROW_VERT = 8'h08;
	localparam logic [7:0] ROW_FDIAG0 = 8'h80;
	localparam logic [7:0] ROW_BDIAG0 = 8'h01;
	localparam logic [7:0] ROW_CHK_EVEN = 8'h55;
	localparam logic [7:0] ROW_CHK_ODD = 8'hAA;
	localparam logic [7:0] ROW_WIDE_EVEN = 8'hCC;
	localparam logic [7:0] ROW_WIDE_ODD = 8'h33;
	localparam logic [7:0] ROW_WALK0 = 8'h88;
	// Tiled pitch granularity in dwords: 512 bytes X-major, 128 bytes Y-major
	localparam logic [15:0] TILEX_DW_MASK = 16'h007F;
	localparam logic [15:0] TILEY_DW_MASK = 16'h001F;
	localparam logic [15:0] ONE16 = 16'h0001;

	typedef enum logic [1:0] {K_FIXED, K_COPY, K_KEYED} bpc_kind_e;

	// First dword of the fixed pattern fill
	typedef struct packed {
		logic [2:0] client;
		logic [6:0] opc;
		logic alpha_we;
		logic rgb_we;
		logic rsv19;
		logic [3:0] pat_sel;
		logic [2:0] hseed;
		logic dst_tile;
		logic [2:0] vseed;
		logic [7:0] len;
	} bpc_hdr_fix_s;

	// First dword of the two copy commands
	typedef struct packed {
		logic [2:0] client;
		logic [6:0] opc;
		logic alpha_we;
		logic rgb_we;
		logic [2:0] key_mode;
		logic rsv16;
		logic src_tile;
		logic [2:0] rsv14;
		logic dst_tile;
		logic [2:0] rsv10;
		logic [7:0] len;
	} bpc_hdr_cpy_s;

	// Depth, raster operation and pitch dword
	typedef struct packed {
		logic rsv31;
		logic clip_en;
		logic rsv29;
		logic transp;
		logic bmask_en;
		logic rsv26;
		logic [1:0] depth;
		logic [7:0] raster_operation_code;
		logic signed [15:0] pitch;
	} bpc_drp_s;

	typedef struct packed {
		logic signed [15:0] y;
		logic signed [15:0] x;
	} bpc_xy_s;

	// One pixel operation handed to the memory side
	typedef struct packed {
		logic [31:0] dst_addr;
		logic [31:0] src_addr;
		logic signed [15:0] x;
		logic signed [15:0] y;
		logic [31:0] color;
		logic we;
		logic alpha_we;
		logic rgb_we;
		logic bmask_en;
		logic src_rd;
		logic [7:0] raster_operation_code;
		logic [1:0] depth;
		logic [2:0] key_mode;
	} bpc_pix_s;
endpackage

// ===== design/bpc_engine.sv
// Blit command interpreter: fixed pattern fill, colour copy and keyed copy.
// Assumes one 10 MHz clock, synchronous active-low reset, a dword command
// stream with valid/ready and a memory side that takes pixel ops by handshake.
`timescale 1ns/1ns
`default_nettype none

// Command FIFO: flip-flop storage, read and write index plus fill count
module bpc_fifo #(
	parameter int W = 32,
	parameter int D = 32
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(D);
	logic [D-1:0][W-1:0] mem_ff;
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;

	// Honest full and empty from the fill count
	assign in_ready_o = (cnt_ff != (AW+1)'(D));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o = mem_ff[rd_ff];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// Pointers and fill count
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(D-1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(D-1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Data words are not reset
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data_i;
		end
	end
endmodule

module bpc_engine #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [31:0] cmd_data_i,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire bpc_pkg::bpc_xy_s clip_tl_i,
	input wire bpc_pkg::bpc_xy_s clip_br_i,
	input wire logic tile_y_i,
	output bpc_pkg::bpc_pix_s pix_o,
	output logic pix_valid_o,
	input wire logic pix_ready_i,
	output logic busy_o,
	output logic bad_cmd_o,
	output logic pitch_err_o
);
	typedef enum logic [2:0] {S_HDR, S_BODY, S_SETUP, S_RUN, S_SKIP} bpc_st_e;

	typedef struct packed {
		bpc_st_e st;
		logic [3:0] idx;
		logic [8:0] left;
		bpc_pkg::bpc_kind_e kind;
		logic [31:0] hdr;
		logic [bpc_pkg::NDW-1:0][31:0] dw;
		logic xback;
		logic yback;
		logic [15:0] ox;
		logic [15:0] oy;
		logic [31:0] dline;
		logic [31:0] sline;
		bpc_pkg::bpc_pix_s pix;
		logic pvld;
		logic bad;
		logic perr;
	} bpc_state_s;

	bpc_state_s cur_ff;
	bpc_state_s nxt_ff;
	logic [31:0] f_data;
	logic f_valid;
	logic f_ready;

	bpc_fifo #(.W(32), .D(FIFO_DEPTH)) u_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.in_data_i(cmd_data_i),
		.in_valid_i(cmd_valid_i),
		.in_ready_o(cmd_ready_o),
		.out_data_o(f_data),
		.out_valid_o(f_valid),
		.out_ready_i(f_ready)
	);

	// Row byte of a fixed bitmap for one scan line
	function automatic logic [7:0] pat_row(input logic [3:0] sel, input logic [2:0] n);
		logic [7:0] fd;
		logic [7:0] bd;
		logic [7:0] hz;
		logic [7:0] wk;
		fd = bpc_pkg::ROW_FDIAG0 >> n;
		bd = bpc_pkg::ROW_BDIAG0 << n;
		hz = (n == bpc_pkg::HORIZ_LINE) ? bpc_pkg::ROW_FULL : bpc_pkg::ROW_NONE;
		wk = bpc_pkg::ROW_WALK0 >> n[1:0];
		case (sel)
			bpc_pkg::PAT_HORIZ: pat_row = hz;
			bpc_pkg::PAT_VERT: pat_row = bpc_pkg::ROW_VERT;
			bpc_pkg::PAT_FDIAG: pat_row = fd;
			bpc_pkg::PAT_BDIAG: pat_row = bd;
			bpc_pkg::PAT_CROSS: pat_row = hz | bpc_pkg::ROW_VERT;
			bpc_pkg::PAT_DCROSS: pat_row = fd | bd;
			bpc_pkg::PAT_CHECK: pat_row = n[0] ? bpc_pkg::ROW_CHK_ODD : bpc_pkg::ROW_CHK_EVEN;
			bpc_pkg::PAT_WIDE: pat_row = n[0] ? bpc_pkg::ROW_WIDE_ODD : bpc_pkg::ROW_WIDE_EVEN;
			bpc_pkg::PAT_WALK1: pat_row = wk;
			bpc_pkg::PAT_WALK0: pat_row = ~wk;
			default: pat_row = bpc_pkg::ROW_NONE;
		endcase
	endfunction

	// Field views of the captured packet
	bpc_pkg::bpc_hdr_fix_s hf;
	bpc_pkg::bpc_hdr_cpy_s hc;
	bpc_pkg::bpc_drp_s drp;
	bpc_pkg::bpc_xy_s dtl;
	bpc_pkg::bpc_xy_s dbr;
	bpc_pkg::bpc_xy_s stl;
	bpc_pkg::bpc_hdr_cpy_s in_h;
	logic signed [15:0] spitch;
	logic signed [15:0] w;
	logic signed [15:0] h;
	logic [1:0] sh;
	assign hf = cur_ff.hdr;
	assign hc = cur_ff.hdr;
	assign in_h = f_data;
	assign drp = cur_ff.dw[0];
	assign dtl = cur_ff.dw[1];
	assign dbr = cur_ff.dw[2];
	assign stl = cur_ff.dw[4];
	assign spitch = cur_ff.dw[5][15:0];
	assign w = dbr.x - dtl.x;
	assign h = dbr.y - dtl.y;
	// Bytes per pixel as a shift
	assign sh = (drp.depth == bpc_pkg::DEPTH_32) ? 2'd2 :
		(drp.depth == bpc_pkg::DEPTH_8) ? 2'd0 : 2'd1;
	assign f_ready = (cur_ff.st == S_HDR) || (cur_ff.st == S_BODY) || (cur_ff.st == S_SKIP);

	localparam logic signed [15:0] ONE_S = bpc_pkg::ONE16;

	// Next state
	always_comb begin
		logic signed [15:0] px;
		logic signed [15:0] py;
		logic signed [15:0] ys;
		logic signed [15:0] sys;
		logic signed [31:0] p4;
		logic signed [31:0] sp4;
		logic [2:0] pb;
		logic [7:0] row;
		logic [31:0] col;
		logic tiled;
		logic good;
		px = '0;
		py = '0;
		ys = '0;
		sys = '0;
		p4 = 32'(drp.pitch) <<< 2;
		sp4 = 32'(spitch) <<< 2;
		pb = '0;
		row = '0;
		col = '0;
		tiled = 1'b0;
		good = 1'b0;
		nxt_ff = cur_ff;
		nxt_ff.bad = 1'b0;
		if (pix_ready_i) begin
			nxt_ff.pvld = 1'b0;
		end
		case (cur_ff.st)
			S_HDR: begin
				if (f_valid) begin
					nxt_ff.hdr = f_data;
					nxt_ff.idx = '0;
					nxt_ff.left = 9'(in_h.len) + 9'd1;
					if (in_h.client == bpc_pkg::CLIENT_2D) begin
						if (in_h.opc == bpc_pkg::OP_COPY && in_h.len == bpc_pkg::LEN_COPY) begin
							nxt_ff.kind = bpc_pkg::K_COPY;
							good = 1'b1;
						end else if (in_h.opc == bpc_pkg::OP_KEYED &&
							in_h.len == bpc_pkg::LEN_KEYED) begin
							nxt_ff.kind = bpc_pkg::K_KEYED;
							good = 1'b1;
						end else if (in_h.opc == bpc_pkg::OP_FIXED &&
							in_h.len == bpc_pkg::LEN_FIXED) begin
							nxt_ff.kind = bpc_pkg::K_FIXED;
							good = 1'b1;
						end
					end
					nxt_ff.st = good ? S_BODY : S_SKIP;
					nxt_ff.bad = !good;
				end
			end
			S_BODY: begin
				if (f_valid) begin
					nxt_ff.dw[cur_ff.idx] = f_data;
					nxt_ff.idx = cur_ff.idx + 4'd1;
					nxt_ff.left = cur_ff.left - 9'd1;
					if (cur_ff.left == 9'd1) begin
						nxt_ff.st = S_SETUP;
					end
				end
			end
			S_SKIP: begin
				if (f_valid) begin
					nxt_ff.left = cur_ff.left - 9'd1;
					if (cur_ff.left == 9'd1) begin
						nxt_ff.st = S_HDR;
					end
				end
			end
			S_SETUP: begin
				// Direction from equal bases only, no true overlap test
				good = (cur_ff.kind != bpc_pkg::K_FIXED) && (cur_ff.dw[3] == cur_ff.dw[6]);
				nxt_ff.xback = good && (stl.x < dtl.x);
				nxt_ff.yback = good && (stl.y < dtl.y);
				ys = nxt_ff.yback ? dbr.y - ONE_S : dtl.y;
				sys = stl.y + (ys - dtl.y);
				nxt_ff.dline = cur_ff.dw[3] + 32'(ys) * p4;
				nxt_ff.sline = cur_ff.dw[6] + 32'(sys) * sp4;
				nxt_ff.ox = '0;
				nxt_ff.oy = '0;
				// Tiled pitch granularity check per surface
				tiled = (cur_ff.kind == bpc_pkg::K_FIXED) ? hf.dst_tile : hc.dst_tile;
				nxt_ff.perr = tiled && ((drp.pitch & (tile_y_i ? bpc_pkg::TILEY_DW_MASK :
					bpc_pkg::TILEX_DW_MASK)) != '0);
				if (cur_ff.kind != bpc_pkg::K_FIXED && hc.src_tile && ((spitch &
					(tile_y_i ? bpc_pkg::TILEY_DW_MASK : bpc_pkg::TILEX_DW_MASK)) != '0)) begin
					nxt_ff.perr = 1'b1;
				end
				nxt_ff.st = (w > 0 && h > 0) ? S_RUN : S_HDR;
			end
			S_RUN: begin
				if (!cur_ff.pvld || pix_ready_i) begin
					px = cur_ff.xback ? dbr.x - ONE_S - cur_ff.ox : dtl.x + cur_ff.ox;
					py = cur_ff.yback ? dbr.y - ONE_S - cur_ff.oy : dtl.y + cur_ff.oy;
					nxt_ff.pix.x = px;
					nxt_ff.pix.y = py;
					nxt_ff.pix.dst_addr = cur_ff.dline + (32'(px) << sh);
					nxt_ff.pix.src_addr = cur_ff.sline + (32'(stl.x + (px - dtl.x)) << sh);
					nxt_ff.pix.raster_operation_code = drp.raster_operation_code;
					nxt_ff.pix.depth = drp.depth;
					nxt_ff.pix.src_rd = (cur_ff.kind != bpc_pkg::K_FIXED);
					nxt_ff.pix.key_mode = (cur_ff.kind == bpc_pkg::K_KEYED) ? hc.key_mode : '0;
					nxt_ff.pix.bmask_en = (cur_ff.kind == bpc_pkg::K_FIXED) && drp.bmask_en;
					nxt_ff.pix.alpha_we = (drp.depth != bpc_pkg::DEPTH_32) || hc.alpha_we;
					nxt_ff.pix.rgb_we = (drp.depth != bpc_pkg::DEPTH_32) || hc.rgb_we;
					nxt_ff.pix.we = 1'b1;
					nxt_ff.pix.color = '0;
					if (cur_ff.kind == bpc_pkg::K_FIXED) begin
						row = pat_row(hf.pat_sel, 3'(py) + hf.vseed);
						pb = 3'(px) + hf.hseed;
						col = row[3'd7 - pb] ? cur_ff.dw[5] : cur_ff.dw[4];
						nxt_ff.pix.color = (drp.depth == bpc_pkg::DEPTH_32) ? col :
							(drp.depth == bpc_pkg::DEPTH_8) ? {24'h000000, col[7:0]} :
							{16'h0000, col[15:0]};
						nxt_ff.pix.we = row[3'd7 - pb] || !drp.transp;
					end
					if (drp.clip_en && (px < clip_tl_i.x || px >= clip_br_i.x ||
						py < clip_tl_i.y || py >= clip_br_i.y)) begin
						nxt_ff.pix.we = 1'b0;
					end
					nxt_ff.pvld = 1'b1;
					nxt_ff.ox = cur_ff.ox + 16'd1;
					if (cur_ff.ox == 16'(w - ONE_S)) begin
						nxt_ff.ox = '0;
						nxt_ff.oy = cur_ff.oy + 16'd1;
						nxt_ff.dline = cur_ff.yback ? cur_ff.dline - p4 : cur_ff.dline + p4;
						nxt_ff.sline = cur_ff.yback ? cur_ff.sline - sp4 : cur_ff.sline + sp4;
						if (cur_ff.oy == 16'(h - ONE_S)) begin
							nxt_ff.st = S_HDR;
						end
					end
				end
			end
			default: nxt_ff.st = S_HDR;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign pix_o = cur_ff.pix;
	assign pix_valid_o = cur_ff.pvld;
	assign busy_o = (cur_ff.st != S_HDR) || cur_ff.pvld;
	assign bad_cmd_o = cur_ff.bad;
	assign pitch_err_o = cur_ff.perr;
endmodule

`default_nettype wire

// ===== testbench/bpc_properties.sv
// Checker for the blit engine pixel and status ports.
// Assumes it is bound into bpc_engine and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module bpc_properties (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [31:0] cmd_data_i,
	input wire logic cmd_valid_i,
	input wire logic cmd_ready_o,
	input wire bpc_pkg::bpc_xy_s clip_tl_i,
	input wire bpc_pkg::bpc_xy_s clip_br_i,
	input wire logic tile_y_i,
	input wire bpc_pkg::bpc_pix_s pix_o,
	input wire logic pix_valid_o,
	input wire logic pix_ready_i,
	input wire logic busy_o,
	input wire logic bad_cmd_o,
	input wire logic pitch_err_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Byte shift of one pixel for each depth code
	function automatic int shf(input logic [1:0] d);
		return d == 2'h0 ? 0 : (d == 2'h3 ? 2 : 1);
	endfunction
	wire acc = pix_valid_o && pix_ready_i;
	sequence s_same_line;
		acc ##1 (pix_valid_o && pix_o.y == $past(pix_o.y));
	endsequence
	// Offered pixel and its fields wait for the memory side
	a_pix_hold: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o && $stable(pix_o))
		else $error("pixel changed while stalled");
	a_bad_pulse: assert property (bad_cmd_o |=> !bad_cmd_o)
		else $error("bad header flag longer than one cycle");
	a_busy_pix: assert property (pix_valid_o |-> busy_o)
		else $error("pixel offered while not busy");
	a_we_narrow: assert property (pix_valid_o && pix_o.depth != 2'h3 |->
		pix_o.alpha_we && pix_o.rgb_we)
		else $error("channel mask applied below 32 bpp");
	a_color_byte: assert property (pix_valid_o && pix_o.depth == 2'h0 |->
		pix_o.color[31:8] == 24'h0)
		else $error("8 bpp colour wider than a byte");
	a_color_half: assert property (pix_valid_o && pix_o.depth inside {2'h1, 2'h2} |->
		pix_o.color[31:16] == 16'h0)
		else $error("16 bpp colour wider than a half");
	a_x_step: assert property (s_same_line |->
		pix_o.x - $past(pix_o.x) == 16'sd1 || $past(pix_o.x) - pix_o.x == 16'sd1)
		else $error("x did not step by one");
	a_addr_step: assert property (s_same_line |-> pix_o.dst_addr - $past(pix_o.dst_addr) ==
		((pix_o.x > $past(pix_o.x) ? 32'h1 : 32'hFFFFFFFF) << shf(pix_o.depth)))
		else $error("address step does not match depth");
	a_y_step: assert property (acc ##1 (pix_valid_o && pix_o.y != $past(pix_o.y)) |->
		pix_o.y - $past(pix_o.y) == 16'sd1 || $past(pix_o.y) - pix_o.y == 16'sd1)
		else $error("line did not step by one");
	a_rop_const: assert property (acc ##1 pix_valid_o |-> $stable(pix_o.raster_operation_code) && $stable(pix_o.depth))
		else $error("operation changed inside a command");
	c_bad: cover property (bad_cmd_o);
	c_stall: cover property (pix_valid_o && !pix_ready_i ##1 pix_valid_o);
	c_full: cover property (!cmd_ready_o);
	c_pitch: cover property (pitch_err_o);
endmodule
bind bpc_engine bpc_properties u_props (.clk_sys_i, .rst_n_i, .cmd_data_i, .cmd_valid_i, .cmd_ready_o,
	.clip_tl_i, .clip_br_i, .tile_y_i, .pix_o, .pix_valid_o, .pix_ready_i, .busy_o, .bad_cmd_o,
	.pitch_err_o);
`default_nettype wire

// ===== testbench/bpc_mem_model.sv
// Graphics memory side: takes pixel operations with random back-pressure.
// Assumes the bench seeds the random generator; stall_i holds it off fully.
`timescale 1ns/1ns
`default_nettype none
module bpc_mem_model (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic stall_i,
	output logic pix_ready_o
);
	// Ready moves only on the falling edge, three beats in four
	always @(negedge clk_sys_i) begin
		pix_ready_o <= rst_n_i && !stall_i && ($urandom % 4 != 0);
	end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench: command packets in, pixel stream compared with a model.
// Assumes bpc_engine, bpc_mem_model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam int CX1 = -3, CY1 = -2, CX2 = 5, CY2 = 4;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, cmd_valid_i = 1'b0, tile_y_i = 1'b0, stall = 1'b1;
	logic [31:0] cmd_data_i = 32'h0;
	bpc_pkg::bpc_xy_s clip_tl_i = {16'(CY1), 16'(CX1)}, clip_br_i = {16'(CY2), 16'(CX2)};
	bpc_pkg::bpc_pix_s pix_o, e;
	logic cmd_ready_o, pix_valid_o, pix_ready_i, busy_o, bad_cmd_o, pitch_err_o, full_seen = 1'b0;
	logic [31:0] pk[$];
	bpc_pkg::bpc_pix_s q[$];
	int kq[$];
	int mismatches = 0, checks = 0, bad_n = 0, cyc = 0, kd;
	always #50 clk_sys_i = ~clk_sys_i;
	bpc_engine uut (.clk_sys_i, .rst_n_i, .cmd_data_i, .cmd_valid_i, .cmd_ready_o, .clip_tl_i,
		.clip_br_i, .tile_y_i, .pix_o, .pix_valid_o, .pix_ready_i, .busy_o, .bad_cmd_o, .pitch_err_o);
	bpc_mem_model u_mem (.clk_sys_i, .rst_n_i, .stall_i(stall), .pix_ready_o(pix_ready_i));
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Fixed bitmap rows, bit 7 is pixel 0
	function automatic logic [7:0] pat(input logic [3:0] s, input int r);
		case (s)
			4'h0: return r == 3 ? 8'hFF : 8'h00;
			4'h1: return 8'h08;
			4'h2: return 8'h80 >> r;
			4'h3: return 8'h01 << r;
			4'h4: return r == 3 ? 8'hFF : 8'h08;
			4'h5: return (8'h80 >> r) | (8'h01 << r);
			4'h8: return r[0] ? 8'hAA : 8'h55;
			4'h9: return r[0] ? 8'h33 : 8'hCC;
			4'hA: return 8'h88 >> r[1:0];
			4'hB: return ~(8'h88 >> r[1:0]);
			default: return 8'h00;
		endcase
	endfunction
	// Model: expected pixels of the packet held in pk
	task automatic gen(input int kind);
		int x1, y1, x2, y2, sx1, sy1, dp, sp, sh, xx, yy;
		logic [31:0] h, d, db, sb, m;
		logic [7:0] row;
		logic xb, yb, b;
		h = pk[0];
		d = pk[1];
		db = pk[4];
		x1 = int'(signed'(pk[2][15:0]));
		y1 = int'(signed'(pk[2][31:16]));
		x2 = int'(signed'(pk[3][15:0]));
		y2 = int'(signed'(pk[3][31:16]));
		dp = int'(signed'(d[15:0]));
		sx1 = int'(signed'(pk[5][15:0]));
		sy1 = int'(signed'(pk[5][31:16]));
		sp = int'(signed'(pk[6][15:0]));
		sb = kind > 0 ? pk[7] : 32'h0;
		sh = d[25:24] == 2'h0 ? 0 : (d[25:24] == 2'h3 ? 2 : 1);
		m = sh == 0 ? 32'hFF : (sh == 1 ? 32'hFFFF : 32'hFFFFFFFF);
		xb = kind > 0 && sb == db && sx1 < x1;
		yb = kind > 0 && sb == db && sy1 < y1;
		for (int j = 0; j < y2 - y1; j++) begin
			for (int i = 0; i < x2 - x1; i++) begin
				yy = yb ? y2 - 1 - j : y1 + j;
				xx = xb ? x2 - 1 - i : x1 + i;
				row = pat(h[18:15], (yy + h[10:8]) & 7);
				b = row[7 - ((xx + h[14:12]) & 7)];
				e = '0;
				e.dst_addr = db + yy * dp * 4 + xx * (1 << sh);
				e.src_addr = sb + (sy1 + yy - y1) * sp * 4 + (sx1 + xx - x1) * (1 << sh);
				e.x = 16'(xx);
				e.y = 16'(yy);
				e.color = kind > 0 ? 32'h0 : ((b ? pk[6] : pk[5]) & m);
				e.we = (!d[30] || (xx >= CX1 && xx < CX2 && yy >= CY1 && yy < CY2)) &&
					(kind > 0 || b || !d[28]);
				e.alpha_we = sh < 2 || h[21];
				e.rgb_we = sh < 2 || h[20];
				e.bmask_en = d[27];
				e.raster_operation_code = d[23:16];
				e.depth = d[25:24];
				e.key_mode = h[19:17];
				q.push_back(e);
				kq.push_back(kind);
			end
		end
	endtask
	// One dword: offered at a falling edge, held until ready is seen high
	task automatic push(input logic [31:0] dw);
		cmd_data_i = dw;
		cmd_valid_i = 1'b1;
		while (cmd_ready_o !== 1'b1) begin
			full_seen = 1'b1;
			@(negedge clk_sys_i);
		end
		@(negedge clk_sys_i);
	endtask
	task automatic send(input int kind);
		gen(kind);
		foreach (pk[i]) push(pk[i]);
		cmd_valid_i = 1'b0;
		@(negedge clk_sys_i);
	endtask
	task automatic fill(input logic [3:0] sel, input logic tl, input logic [15:0] p, input int w);
		int x1, y1;
		x1 = int'($urandom % 16) - 8;
		y1 = int'($urandom % 16) - 8;
		pk = {};
		pk.push_back({3'h2, 7'h59, 2'($urandom), 1'b0, sel, 3'($urandom), tl, 3'($urandom), 8'h05});
		pk.push_back({1'b0, 1'($urandom), 1'b0, 2'($urandom), 1'b0, 2'($urandom), 8'hF0, p});
		pk.push_back({16'(y1), 16'(x1)});
		pk.push_back({16'(y1 + 2 + int'($urandom % 7)), 16'(x1 + w)});
		pk.push_back(32'h0008_0000);
		pk.push_back($urandom);
		pk.push_back($urandom);
		send(0);
	endtask
	task automatic copy(input int k);
		int dx, dy;
		dx = int'($urandom % 8);
		dy = int'($urandom % 8);
		pk = {};
		pk.push_back({3'h2, k == 3 ? 7'h73 : 7'h53, 2'($urandom), 3'(k == 3 ? $urandom : 0), 1'b0,
			k == 3, 3'h0, k == 3, 3'h0, k == 3 ? 8'h08 : 8'h06});
		pk.push_back({1'b0, 1'($urandom), 4'h0, 2'($urandom), 8'hCC,
			k == 2 ? 16'hFFC0 : 16'h0080});
		pk.push_back({16'(dy), 16'(dx)});
		pk.push_back({16'(dy + 3), 16'(dx + 4)});
		pk.push_back(32'h0010_0000);
		pk.push_back({16'(k == 1 || k == 2 ? dy - 1 : dy + 1), 16'(k == 0 ? dx + 2 : dx - 2)});
		pk.push_back({16'h0000, 16'h0100});
		pk.push_back(k == 2 ? 32'h0020_0000 : 32'h0010_0000);
		if (k == 3) begin
			pk.push_back($urandom);
			pk.push_back($urandom);
		end
		send(k == 3 ? 2 : 1);
	endtask
	task automatic idle;
		repeat (20) @(negedge clk_sys_i);
		while (q.size() != 0 || busy_o !== 1'b0) @(negedge clk_sys_i);
	endtask
	// Compare every accepted pixel with the model
	always @(posedge clk_sys_i) begin
		if (rst_n_i && pix_valid_o === 1'b1 && pix_ready_i) begin
			if (q.size() == 0) chk("extra_pixel", 32'h0, 32'h1);
			else begin
				e = q.pop_front();
				kd = kq.pop_front();
				chk("dst_addr", e.dst_addr, pix_o.dst_addr);
				chk("x", e.x, pix_o.x);
				chk("y", e.y, pix_o.y);
				chk("alpha_we", e.alpha_we, pix_o.alpha_we);
				chk("rgb_we", e.rgb_we, pix_o.rgb_we);
				chk("depth", e.depth, pix_o.depth);
				chk("rop", e.raster_operation_code, pix_o.raster_operation_code);
				chk("color", e.color, pix_o.color);
				chk("we", e.we, pix_o.we);
				if (kd == 0) begin
					chk("bmask_en", e.bmask_en, pix_o.bmask_en);
					chk("src_rd", 32'h0, pix_o.src_rd);
				end else begin
					chk("src_addr", e.src_addr, pix_o.src_addr);
					chk("src_rd", 32'h1, pix_o.src_rd);
					if (kd == 2) chk("key_mode", e.key_mode, pix_o.key_mode);
				end
			end
		end
		if (bad_cmd_o === 1'b1) bad_n++;
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			tally_and_finish;
		end
	end
	initial begin
		void'($urandom(36));
		repeat (10) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		// Every selector, memory stalled first so the command queue fills
		fork
			for (int i = 0; i < 16; i++) begin
				fill(4'(i), 1'b0, 16'h0040, i == 7 ? 0 : 3 + int'($urandom % 6));
			end
			begin
				repeat (300) @(negedge clk_sys_i);
				stall = 1'b0;
			end
		join
		idle;
		chk("queue_refused", 32'h1, full_seen);
		for (int k = 0; k < 4; k++) copy(k);
		idle;
		// Unknown opcode, short copy length, wrong client
		pk = {};
		push({3'h2, 7'h11, 14'h0, 8'h02});
		repeat (3) push($urandom);
		push({3'h2, 7'h53, 14'h0, 8'h05});
		repeat (6) push($urandom);
		push({3'h3, 7'h59, 14'h0, 8'h05});
		repeat (6) push($urandom);
		cmd_valid_i = 1'b0;
		idle;
		chk("bad_cmd_count", 32'd3, bad_n);
		fill(4'h4, 1'b1, 16'h0020, 3);
		idle;
		chk("pitch_err_x", 32'h1, pitch_err_o);
		tile_y_i = 1'b1;
		fill(4'h5, 1'b1, 16'h0020, 3);
		idle;
		chk("pitch_err_y", 32'h0, pitch_err_o);
		tally_and_finish;
	end
endmodule
`default_nettype wire
